// ===== rtl/uefc_pkg.sv
// Constants, types and register decode for the enhanced flow control block.
// Assumes one 100 MHz clock and an 8-bit host register port with three address lines.
package uefc_pkg;

  localparam int DW = 8;
  localparam int AW = 3;
  localparam int LVL_W = 7;
  localparam int SYNC_W = 20;

  // Register offsets on the host port
  localparam logic [2:0] OFS_0 = 3'h0;
  localparam logic [2:0] OFS_1 = 3'h1;
  localparam logic [2:0] OFS_2 = 3'h2;
  localparam logic [2:0] OFS_3 = 3'h3;
  localparam logic [2:0] OFS_4 = 3'h4;
  localparam logic [2:0] OFS_5 = 3'h5;
  localparam logic [2:0] OFS_6 = 3'h6;
  localparam logic [2:0] OFS_7 = 3'h7;
  localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
  localparam int LCR_DLAB = 7;

  // Reset values
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] LSR_RST = 8'h60;
  localparam logic [7:0] SPR_RST = 8'hFF;
  localparam logic [7:0] FIFO_READY_STATUS_RST = 8'hFF;
  localparam logic [7:0] DLM_POR = 8'h00;
  localparam logic [7:0] DLL_POR = 8'h01;
  localparam logic [SYNC_W-1:0] SYNC_RST = 20'h7_C007;

  // Field positions
  localparam int EFR_ENH = 4;
  localparam int EFR_SPECIAL = 5;
  localparam int EFR_ARTS = 6;
  localparam int EFR_ACTS = 7;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OUT2 = 3;
  localparam int IER_RXDATA = 0;
  localparam int IER_SPECIAL = 5;
  localparam int IER_RTS = 6;
  localparam int IER_CTS = 7;
  localparam int ISR_NOINT = 0;
  localparam int ISR_SPECIAL = 4;
  localparam int ISR_HWFC = 5;
  localparam int FCR_TRIG_LSB = 6;
  localparam int MSR_RI = 2;

  // Bits guarded by the enhanced-enable bit
  localparam logic [7:0] IER_PROT = 8'hF0;
  localparam logic [7:0] FCR_PROT = 8'h30;
  localparam logic [7:0] MCR_PROT = 8'hE0;
  localparam logic [7:0] DLD_PROT = 8'hFF;

  // Receive FIFO trigger levels and depth
  localparam logic [LVL_W-1:0] TRIG_L0 = 7'h08;
  localparam logic [LVL_W-1:0] TRIG_L1 = 7'h10;
  localparam logic [LVL_W-1:0] TRIG_L2 = 7'h38;
  localparam logic [LVL_W-1:0] TRIG_L3 = 7'h3C;
  localparam logic [LVL_W-1:0] FIFO_DEPTH = 7'h40;
  localparam logic [LVL_W-1:0] LVL_ONE = 7'h01;

  typedef enum logic [1:0] {
    FC_NONE = 2'b00,
    FC_PAIR2 = 2'b01,
    FC_PAIR1 = 2'b10,
    FC_BOTH = 2'b11
  } uefc_fc_t;

  typedef enum logic [2:0] {
    TS_IDLE = 3'b001,
    TS_FIRST = 3'b010,
    TS_SECOND = 3'b100
  } uefc_txs_t;

  typedef enum logic [4:0] {
    RG_NONE, RG_DLL, RG_DLM, RG_DLD, RG_IER, RG_ISR_FCR, RG_LCR, RG_MCR,
    RG_LSR, RG_MSR, RG_SPR, RG_EFR, RG_RESUME_CHAR_1, RG_RESUME_CHAR_2, RG_PAUSE_CHAR_1, RG_PAUSE_CHAR_2
  } uefc_reg_t;

  function automatic uefc_reg_t uefc_decode(input logic [2:0] a, input logic [7:0] line_control_reg);
    uefc_reg_t r;
    r = RG_NONE;
    case (a)
      OFS_0: r = line_control_reg[LCR_DLAB] ? RG_DLL : RG_NONE;
      OFS_1: r = line_control_reg[LCR_DLAB] ? RG_DLM : RG_IER;
      OFS_2: r = (line_control_reg == LCR_ENH_KEY) ? RG_EFR : (line_control_reg[LCR_DLAB] ? RG_DLD : RG_ISR_FCR);
      OFS_3: r = RG_LCR;
      OFS_4: r = (line_control_reg == LCR_ENH_KEY) ? RG_RESUME_CHAR_1 : RG_MCR;
      OFS_5: r = (line_control_reg == LCR_ENH_KEY) ? RG_RESUME_CHAR_2 : RG_LSR;
      OFS_6: r = (line_control_reg == LCR_ENH_KEY) ? RG_PAUSE_CHAR_1 : RG_MSR;
      OFS_7: r = (line_control_reg == LCR_ENH_KEY) ? RG_PAUSE_CHAR_2 : RG_SPR;
      default: r = RG_NONE;
    endcase
    return r;
  endfunction

endpackage

// ===== rtl/uefc_match_if.sv
// Signals between the register core and the receive character matcher.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface uefc_match_if;
  import uefc_pkg::*;
  logic [7:0] rx_char;
  logic rx_valid;
  uefc_fc_t rx_mode;
  uefc_fc_t tx_mode;
  logic special_en;
  logic [7:0] resume_char_1;
  logic [7:0] resume_char_2;
  logic [7:0] pause_char_1;
  logic [7:0] pause_char_2;
  logic pause_hit;
  logic resume_hit;
  logic special_hit;
  logic store_char;

  modport matcher (
    input rx_char, rx_valid, rx_mode, tx_mode, special_en, resume_char_1, resume_char_2, pause_char_1, pause_char_2,
    output pause_hit, resume_hit, special_hit, store_char
  );
  modport owner (
    output rx_char, rx_valid, rx_mode, tx_mode, special_en, resume_char_1, resume_char_2, pause_char_1, pause_char_2,
    input pause_hit, resume_hit, special_hit, store_char
  );
endinterface

// ===== rtl/uefc_rxmatch.sv
// Compares received characters with the pause and resume characters.
// Assumes one character per rx_valid pulse, on the core clock.
`timescale 1ns/1ps
module uefc_rxmatch (
  input wire logic CLK,
  input wire logic RST,
  uefc_match_if.matcher m
);
  import uefc_pkg::*;

  logic first_pause_reg;
  logic first_resume_reg;
  logic seq_mode;
  logic either_mode;
  logic p1;
  logic p2;
  logic r1;
  logic r2;

  assign p1 = (m.rx_char == m.pause_char_1);
  assign p2 = (m.rx_char == m.pause_char_2);
  assign r1 = (m.rx_char == m.resume_char_1);
  assign r2 = (m.rx_char == m.resume_char_2);
  // Either pair singly only when one transmit pair is in use
  assign either_mode = (m.rx_mode == FC_BOTH) && (m.tx_mode == FC_PAIR1 || m.tx_mode == FC_PAIR2);
  assign seq_mode = (m.rx_mode == FC_BOTH) && !either_mode;

  // Sequence tracking: any other character breaks a half-seen pair
  always_ff @(posedge CLK) begin
    if (RST) begin
      first_pause_reg <= 1'b0;
      first_resume_reg <= 1'b0;
    end else if (m.rx_valid) begin
      first_pause_reg <= seq_mode && p1;
      first_resume_reg <= seq_mode && r1;
    end
  end

  always_comb begin
    m.pause_hit = 1'b0;
    m.resume_hit = 1'b0;
    if (m.rx_valid) begin
      unique case (m.rx_mode)
        FC_NONE: begin
          m.pause_hit = 1'b0;
          m.resume_hit = 1'b0;
        end
        FC_PAIR1: begin
          m.pause_hit = p1;
          m.resume_hit = r1;
        end
        FC_PAIR2: begin
          m.pause_hit = p2;
          m.resume_hit = r2;
        end
        FC_BOTH: begin
          m.pause_hit = either_mode ? (p1 | p2) : (first_pause_reg & p2);
          m.resume_hit = either_mode ? (r1 | r2) : (first_resume_reg & r2);
        end
      endcase
    end
  end

  // Bit-for-bit match, bit 0 against the first received bit
  assign m.special_hit = m.rx_valid && m.special_en && p2;
  // A consumed flow character never reaches the FIFO
  assign m.store_char = m.rx_valid && !(m.pause_hit || m.resume_hit);

endmodule

// ===== rtl/uefc_top.sv
// Enhanced feature and flow control logic of one UART channel.
// Assumes host strobes and modem pins are asynchronous; receiver, FIFO and
// transmitter hooks run on CLK.
`timescale 1ns/1ps
module uefc_top #(
  parameter bit CONTINUOUS_INT = 1'b0
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic POR,
  input wire logic CS_N,
  input wire logic IOR_N,
  input wire logic IOW_N,
  input wire logic [uefc_pkg::AW-1:0] ADDR,
  input wire logic [uefc_pkg::DW-1:0] DATA_IN,
  output logic [uefc_pkg::DW-1:0] DATA_OUT,
  output logic DATA_OE_N,
  input wire logic STATUS_SELECT_IN_N,
  input wire logic INTERRUPT_MODE_SELECT,
  input wire logic CTS_N,
  input wire logic DSR_N,
  input wire logic RI_N,
  input wire logic CD_N,
  input wire logic [uefc_pkg::DW-1:0] RX_CHAR,
  input wire logic RX_CHAR_VALID,
  output logic RX_STORE_VALID,
  output logic [uefc_pkg::DW-1:0] RX_STORE_DATA,
  input wire logic [uefc_pkg::LVL_W-1:0] RX_FIFO_LEVEL,
  output logic TX_GO,
  output logic FLOW_CHAR_VALID,
  output logic [uefc_pkg::DW-1:0] FLOW_CHAR,
  input wire logic FLOW_CHAR_READY,
  input wire logic [uefc_pkg::DW-1:0] LSR_STATUS,
  input wire logic TX_SERIAL_IN,
  output logic TX,
  input wire logic INFRARED_TX_IN,
  output logic INFRARED_TX_OUT,
  input wire logic [3:0] CH_RX_READY_N,
  input wire logic [3:0] CH_TX_READY_N,
  output logic RECEIVE_READY_OUT_N,
  output logic TRANSMIT_READY_OUT_N,
  output logic RTS_N,
  output logic DTR_N,
  output logic INT_OUT,
  output logic INT_OE_N,
  output logic IRQ_N_OUT,
  output logic IRQ_OE_N,
  output logic [15:0] DIVISOR,
  output logic [uefc_pkg::DW-1:0] FRAC_DIVISOR
);
  import uefc_pkg::*;

  logic rst_any;
  logic [SYNC_W-1:0] sync_in, sync1_reg, sync2_reg;
  logic iow_d_reg, ior_d_reg;
  logic cs_act, ior_act, iow_act, status_select_in_act, interrupt_mode_select_s;
  logic [2:0] addr_s;
  logic [7:0] data_s;
  logic [3:0] msr_s, msr_prev_reg, msr_delta_reg, msr_change;
  logic wr_stb, rd_done;
  uefc_reg_t sel;
  logic [7:0] ier_reg, fcr_reg, lcr_reg, mcr_reg, spr_reg, dld_reg, efr_reg, lsr_reg;
  logic [7:0] resume_char_1_reg, resume_char_2_reg, pause_char_1_reg, pause_char_2_reg, dll_reg, dlm_reg, fifo_ready_status_reg;
  logic [7:0] rd_mux, rd_data_reg, isr_val;
  logic isr_sc_reg, isr_hw_reg, int_req, int_reg;
  logic remote_paused_reg, rts_hold_reg, cts_halt, cts_halt_d_reg, rts_hold_d_reg;
  logic [LVL_W-1:0] trig_lvl, upper_lvl, lower_lvl;
  logic rx_trig, want_pause, sent_paused_reg, kind_reg;
  uefc_txs_t txs_reg;
  uefc_fc_t tx_mode, rx_mode;
  logic [7:0] flow_char_reg;
  logic store_valid_reg;
  logic [7:0] store_data_reg;
  logic tx_reg, infrared_tx_out_reg, receive_ready_out_reg, transmit_ready_out_reg;
  uefc_match_if mif ();

  function automatic logic [7:0] guard(input logic [7:0] old, input logic [7:0] nw,
                                       input logic [7:0] mask, input logic en);
    return en ? nw : ((old & mask) | (nw & ~mask));
  endfunction

  function automatic logic [LVL_W-1:0] trig_at(input logic [2:0] idx);
    logic [LVL_W-1:0] l;
    l = FIFO_DEPTH;
    case (idx)
      3'd0: l = TRIG_L0;
      3'd1: l = TRIG_L1;
      3'd2: l = TRIG_L2;
      3'd3: l = TRIG_L3;
      default: l = FIFO_DEPTH;
    endcase
    return l;
  endfunction

  assign rst_any = RST | POR;

  // Two-stage synchroniser for every host and modem pin
  assign sync_in = {INTERRUPT_MODE_SELECT, CD_N, RI_N, DSR_N, CTS_N, STATUS_SELECT_IN_N,
                    DATA_IN, ADDR, IOW_N, IOR_N, CS_N};
  always_ff @(posedge CLK) begin
    if (rst_any) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else begin
      sync1_reg <= sync_in;
      sync2_reg <= sync1_reg;
    end
  end

  assign cs_act = ~sync2_reg[0];
  assign ior_act = ~sync2_reg[1];
  assign iow_act = ~sync2_reg[2];
  assign addr_s = sync2_reg[5:3];
  assign data_s = sync2_reg[13:6];
  assign status_select_in_act = ~sync2_reg[14];
  assign msr_s = ~sync2_reg[18:15];
  assign interrupt_mode_select_s = sync2_reg[19];

  always_ff @(posedge CLK) begin
    if (rst_any) begin
      iow_d_reg <= 1'b0;
      ior_d_reg <= 1'b0;
    end else begin
      iow_d_reg <= iow_act;
      ior_d_reg <= ior_act;
    end
  end

  // Act at the trailing edge of the strobe, when address and data are settled
  assign wr_stb = cs_act && iow_d_reg && !iow_act;
  assign rd_done = cs_act && ior_d_reg && !ior_act;
  assign sel = uefc_decode(addr_s, lcr_reg);

  always_ff @(posedge CLK) begin
    if (rst_any) begin
      ier_reg <= ZERO8;
      fcr_reg <= ZERO8;
      lcr_reg <= ZERO8;
      mcr_reg <= ZERO8;
      dld_reg <= ZERO8;
      efr_reg <= ZERO8;
      spr_reg <= SPR_RST;
      resume_char_1_reg <= ZERO8;
      resume_char_2_reg <= ZERO8;
      pause_char_1_reg <= ZERO8;
      pause_char_2_reg <= ZERO8;
    end else if (wr_stb) begin
      case (sel)
        RG_IER: ier_reg <= guard(ier_reg, data_s, IER_PROT, efr_reg[EFR_ENH]);
        RG_ISR_FCR: fcr_reg <= guard(fcr_reg, data_s, FCR_PROT, efr_reg[EFR_ENH]);
        RG_MCR: mcr_reg <= guard(mcr_reg, data_s, MCR_PROT, efr_reg[EFR_ENH]);
        RG_DLD: dld_reg <= guard(dld_reg, data_s, DLD_PROT, efr_reg[EFR_ENH]);
        RG_LCR: lcr_reg <= data_s;
        RG_SPR: spr_reg <= data_s;
        RG_EFR: efr_reg <= data_s;
        RG_RESUME_CHAR_1: resume_char_1_reg <= data_s;
        RG_RESUME_CHAR_2: resume_char_2_reg <= data_s;
        RG_PAUSE_CHAR_1: pause_char_1_reg <= data_s;
        RG_PAUSE_CHAR_2: pause_char_2_reg <= data_s;
        default: ;
      endcase
    end
  end

  // Divisor survives the reset pin; only power-up loads it
  always_ff @(posedge CLK) begin
    if (POR) begin
      dlm_reg <= DLM_POR;
      dll_reg <= DLL_POR;
    end else if (wr_stb && sel == RG_DLL) begin
      dll_reg <= data_s;
    end else if (wr_stb && sel == RG_DLM) begin
      dlm_reg <= data_s;
    end
  end
  assign DIVISOR = {dlm_reg, dll_reg};
  assign FRAC_DIVISOR = dld_reg;

  // Status copies
  always_ff @(posedge CLK) begin
    if (rst_any) begin
      lsr_reg <= LSR_RST;
      fifo_ready_status_reg <= FIFO_READY_STATUS_RST;
    end else begin
      lsr_reg <= LSR_STATUS;
      fifo_ready_status_reg <= {CH_RX_READY_N, ~CH_TX_READY_N};
    end
  end

  // Modem status: deltas set on change (RI only on assertion), cleared by reading; set wins
  assign msr_change = {msr_s[3], ~msr_prev_reg[MSR_RI] & msr_s[MSR_RI], msr_s[1:0]} ^
                      {msr_prev_reg[3], 1'b0, msr_prev_reg[1:0]};
  always_ff @(posedge CLK) begin
    if (rst_any) begin
      msr_prev_reg <= msr_s;
      msr_delta_reg <= 4'h0;
    end else begin
      msr_prev_reg <= msr_s;
      msr_delta_reg <= msr_change | ((rd_done && sel == RG_MSR) ? 4'h0 : msr_delta_reg);
    end
  end

  assign tx_mode = uefc_fc_t'(efr_reg[3:2]);
  assign rx_mode = uefc_fc_t'(efr_reg[1:0]);

  assign mif.rx_char = RX_CHAR;
  assign mif.rx_valid = RX_CHAR_VALID;
  assign mif.rx_mode = rx_mode;
  assign mif.tx_mode = tx_mode;
  assign mif.special_en = efr_reg[EFR_SPECIAL];
  assign mif.resume_char_1 = resume_char_1_reg;
  assign mif.resume_char_2 = resume_char_2_reg;
  assign mif.pause_char_1 = pause_char_1_reg;
  assign mif.pause_char_2 = pause_char_2_reg;

  uefc_rxmatch u_match (
    .CLK(CLK),
    .RST(rst_any),
    .m(mif.matcher)
  );

  always_ff @(posedge CLK) begin
    if (rst_any) begin
      store_valid_reg <= 1'b0;
      store_data_reg <= ZERO8;
    end else begin
      store_valid_reg <= mif.store_char;
      store_data_reg <= RX_CHAR;
    end
  end
  assign RX_STORE_VALID = store_valid_reg;
  assign RX_STORE_DATA = store_data_reg;

  // Remote pause state
  always_ff @(posedge CLK) begin
    if (rst_any || rx_mode == FC_NONE) begin
      remote_paused_reg <= 1'b0;
    end else if (mif.pause_hit) begin
      remote_paused_reg <= 1'b1;
    end else if (mif.resume_hit) begin
      remote_paused_reg <= 1'b0;
    end
  end

  // Trigger and hysteresis levels
  assign trig_lvl = trig_at({1'b0, fcr_reg[FCR_TRIG_LSB+1:FCR_TRIG_LSB]});
  assign upper_lvl = trig_at({1'b0, fcr_reg[FCR_TRIG_LSB+1:FCR_TRIG_LSB]} + 3'd1);
  assign lower_lvl = (fcr_reg[FCR_TRIG_LSB+1:FCR_TRIG_LSB] == 2'b00) ? LVL_ONE :
                     trig_at({1'b0, fcr_reg[FCR_TRIG_LSB+1:FCR_TRIG_LSB]} - 3'd1);
  assign rx_trig = RX_FIFO_LEVEL >= trig_lvl;

  // Hold only engages once software has asserted RTS
  always_ff @(posedge CLK) begin
    if (rst_any || !efr_reg[EFR_ARTS] || !mcr_reg[MCR_RTS]) begin
      rts_hold_reg <= 1'b0;
    end else if (RX_FIFO_LEVEL >= upper_lvl) begin
      rts_hold_reg <= 1'b1;
    end else if (RX_FIFO_LEVEL < lower_lvl) begin
      rts_hold_reg <= 1'b0;
    end
  end
  assign RTS_N = ~mcr_reg[MCR_RTS] | rts_hold_reg;
  assign DTR_N = ~mcr_reg[MCR_DTR];

  // Transmitter checks TX_GO only before loading a new character
  assign cts_halt = efr_reg[EFR_ACTS] & ~msr_s[0];
  assign TX_GO = ~(cts_halt | remote_paused_reg);

  // Software flow transmit: pause at trigger, resume once drained below it
  assign want_pause = rx_trig;
  always_ff @(posedge CLK) begin
    if (rst_any || tx_mode == FC_NONE) begin
      txs_reg <= TS_IDLE;
      sent_paused_reg <= 1'b0;
      kind_reg <= 1'b0;
      flow_char_reg <= ZERO8;
    end else begin
      unique case (txs_reg)
        TS_IDLE: begin
          if (want_pause != sent_paused_reg) begin
            txs_reg <= TS_FIRST;
            kind_reg <= want_pause;
            if (tx_mode == FC_PAIR2) begin
              flow_char_reg <= want_pause ? pause_char_2_reg : resume_char_2_reg;
            end else begin
              flow_char_reg <= want_pause ? pause_char_1_reg : resume_char_1_reg;
            end
          end
        end
        TS_FIRST: begin
          if (FLOW_CHAR_READY) begin
            if (tx_mode == FC_BOTH) begin
              txs_reg <= TS_SECOND;
              flow_char_reg <= kind_reg ? pause_char_2_reg : resume_char_2_reg;
            end else begin
              txs_reg <= TS_IDLE;
              sent_paused_reg <= kind_reg;
            end
          end
        end
        TS_SECOND: begin
          if (FLOW_CHAR_READY) begin
            txs_reg <= TS_IDLE;
            sent_paused_reg <= kind_reg;
          end
        end
      endcase
    end
  end
  assign FLOW_CHAR_VALID = (txs_reg != TS_IDLE);
  assign FLOW_CHAR = flow_char_reg;

  // Interrupt status flags: a new event in the clearing cycle is kept
  always_ff @(posedge CLK) begin
    if (rst_any) begin
      isr_sc_reg <= 1'b0;
      isr_hw_reg <= 1'b0;
      cts_halt_d_reg <= 1'b0;
      rts_hold_d_reg <= 1'b0;
    end else begin
      cts_halt_d_reg <= cts_halt;
      rts_hold_d_reg <= rts_hold_reg;
      if (mif.special_hit || mif.pause_hit) begin
        isr_sc_reg <= 1'b1;
      end else if (rd_done && sel == RG_ISR_FCR) begin
        isr_sc_reg <= 1'b0;
      end
      if ((cts_halt && !cts_halt_d_reg) || (rts_hold_reg && !rts_hold_d_reg)) begin
        isr_hw_reg <= 1'b1;
      end else if (rd_done && sel == RG_ISR_FCR) begin
        isr_hw_reg <= 1'b0;
      end
    end
  end

  assign int_req = (isr_sc_reg & ier_reg[IER_SPECIAL]) |
                   (isr_hw_reg & (ier_reg[IER_RTS] | ier_reg[IER_CTS])) |
                   (rx_trig & ier_reg[IER_RXDATA]);

  always_comb begin
    isr_val = ZERO8;
    isr_val[ISR_NOINT] = ~int_req;
    isr_val[ISR_SPECIAL] = isr_sc_reg;
    isr_val[ISR_HWFC] = isr_hw_reg;
  end

  always_comb begin
    case (sel)
      RG_DLL: rd_mux = dll_reg;
      RG_DLM: rd_mux = dlm_reg;
      RG_DLD: rd_mux = dld_reg;
      RG_IER: rd_mux = ier_reg;
      RG_ISR_FCR: rd_mux = isr_val;
      RG_LCR: rd_mux = lcr_reg;
      RG_MCR: rd_mux = mcr_reg;
      RG_LSR: rd_mux = lsr_reg;
      RG_MSR: rd_mux = {msr_s, msr_delta_reg};
      RG_SPR: rd_mux = spr_reg;
      RG_EFR: rd_mux = efr_reg;
      RG_RESUME_CHAR_1: rd_mux = resume_char_1_reg;
      RG_RESUME_CHAR_2: rd_mux = resume_char_2_reg;
      RG_PAUSE_CHAR_1: rd_mux = pause_char_1_reg;
      RG_PAUSE_CHAR_2: rd_mux = pause_char_2_reg;
      default: rd_mux = ZERO8;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (rst_any) begin
      rd_data_reg <= ZERO8;
    end else begin
      rd_data_reg <= status_select_in_act ? fifo_ready_status_reg : rd_mux;
    end
  end
  assign DATA_OUT = rd_data_reg;
  assign DATA_OE_N = ~((cs_act && ior_act) || status_select_in_act);

  // Pin copies; reset forces the idle levels
  always_ff @(posedge CLK) begin
    if (rst_any) begin
      tx_reg <= 1'b1;
      infrared_tx_out_reg <= 1'b0;
      receive_ready_out_reg <= 1'b1;
      transmit_ready_out_reg <= 1'b0;
      int_reg <= 1'b0;
    end else begin
      tx_reg <= TX_SERIAL_IN;
      infrared_tx_out_reg <= INFRARED_TX_IN;
      receive_ready_out_reg <= CH_RX_READY_N[0];
      transmit_ready_out_reg <= CH_TX_READY_N[0];
      int_reg <= int_req;
    end
  end
  assign TX = tx_reg;
  assign INFRARED_TX_OUT = infrared_tx_out_reg;
  assign RECEIVE_READY_OUT_N = receive_ready_out_reg;
  assign TRANSMIT_READY_OUT_N = transmit_ready_out_reg;

  // Three-state interrupt gated by mode select or OUT2; variant always drives
  assign INT_OUT = int_reg;
  assign INT_OE_N = CONTINUOUS_INT ? 1'b0 : ~(interrupt_mode_select_s | mcr_reg[MCR_OUT2]);
  assign IRQ_N_OUT = 1'b0;
  assign IRQ_OE_N = ~int_reg;

endmodule

// ===== testbench/uefc_top_properties.sv
// Checker: pin-level timing relations of the flow control block.
// Assumes binding to uefc_top; everything runs on CLK.
`timescale 1ns/1ps
module uefc_top_properties (
  input wire logic CLK,
  input wire logic RST,
  input wire logic POR,
  input wire logic STATUS_SELECT_IN_N,
  input wire logic DATA_OE_N,
  input wire logic RX_CHAR_VALID,
  input wire logic RX_STORE_VALID,
  input wire logic FLOW_CHAR_VALID,
  input wire logic FLOW_CHAR_READY,
  input wire logic [uefc_pkg::DW-1:0] FLOW_CHAR,
  input wire logic TX,
  input wire logic INFRARED_TX_OUT,
  input wire logic RTS_N,
  input wire logic DTR_N,
  input wire logic RECEIVE_READY_OUT_N,
  input wire logic TRANSMIT_READY_OUT_N,
  input wire logic IRQ_N_OUT,
  input wire logic IRQ_OE_N,
  input wire logic [15:0] DIVISOR
);
  default clocking cb @(posedge CLK); endclocking
  chk_pins_reset: assert property ((RST || POR) |=> TX && !INFRARED_TX_OUT)
    else $error("serial pins not idle after reset");
  chk_modem_reset: assert property ((RST || POR) |=> RTS_N && DTR_N)
    else $error("modem outputs not high after reset");
  chk_ready_reset: assert property ((RST || POR) |=> RECEIVE_READY_OUT_N && !TRANSMIT_READY_OUT_N)
    else $error("ready pins wrong after reset");
  chk_div_power: assert property (POR |=> DIVISOR == 16'h0001)
    else $error("divisor not loaded at power-up");
  // Pin reset must not disturb the baud divisor
  chk_div_keep: assert property (RST && !POR |=> $stable(DIVISOR))
    else $error("divisor changed by reset pin");
  chk_store_cause: assert property (disable iff (RST || POR) RX_STORE_VALID |-> $past(RX_CHAR_VALID))
    else $error("store pulse without received character");
  chk_flow_hold: assert property (disable iff (RST || POR)
    FLOW_CHAR_VALID && !FLOW_CHAR_READY |=> FLOW_CHAR_VALID && $stable(FLOW_CHAR))
    else $error("flow character dropped before acceptance");
  // Four samples cover the two-flop input synchroniser
  chk_fifo_ready_status_drive: assert property (disable iff (RST || POR) !STATUS_SELECT_IN_N [*4] |-> !DATA_OE_N)
    else $error("status select low but bus not driven");
  chk_irq_low: assert property ((RST || POR) |=> IRQ_OE_N && !IRQ_N_OUT)
    else $error("interrupt request not floating after reset");
endmodule
bind uefc_top uefc_top_properties i_uefc_top_properties (.CLK, .RST, .POR, .STATUS_SELECT_IN_N, .DATA_OE_N,
  .RX_CHAR_VALID, .RX_STORE_VALID, .FLOW_CHAR_VALID, .FLOW_CHAR_READY, .FLOW_CHAR, .TX, .INFRARED_TX_OUT,
  .RTS_N, .DTR_N, .RECEIVE_READY_OUT_N, .TRANSMIT_READY_OUT_N, .IRQ_N_OUT, .IRQ_OE_N, .DIVISOR);

// ===== testbench/uefc_peer.sv
// Far-side transmitter taking pause and resume characters.
// Assumes the valid/ready handshake on the core clock.
`timescale 1ns/1ps
module uefc_peer (
  input wire logic clk,
  input wire logic valid,
  input wire logic [7:0] ch,
  output logic ready,
  output logic [7:0] last,
  output int num
);
  int wait_cnt = 0;
  initial begin
    ready = 1'b0;
    last = 8'h00;
    num = 0;
  end
  // Slow on purpose, so the device must hold its request
  always @(posedge clk) begin
    ready <= 1'b0;
    if (valid && ready) begin
      last <= ch;
      num <= num + 1;
      wait_cnt <= 0;
    end else if (valid) begin
      wait_cnt <= wait_cnt + 1;
      ready <= (wait_cnt == 2);
    end
  end
endmodule

// ===== testbench/uefc_top_tb.sv
// Testbench: host register cycles, flow and pin scenarios.
// Assumes the design, checker and peer files are compiled first.
`timescale 1ns/1ps
module uefc_top_tb;
  import uefc_pkg::*;
  logic clk = 0, rst = 1, por = 1, cs_n = 1, ior_n = 1, iow_n = 1, ss_n = 1, cts_n = 0, rxv = 0, txs = 1;
  logic [2:0] adr = 0;
  logic [7:0] din = 0, rxc = 0, dout, fc, rsd, last;
  logic [6:0] lvl = 0;
  logic [3:0] rrdy = 4'hF, trdy = 4'h0;
  logic rsv, go, fcv, fifo_control_reg, rts;
  logic [15:0] dv;
  int error_cnt = 0, comparisons = 0, num;
  always #5 clk = ~clk;
  uefc_top i_uefc_top (.CLK(clk), .RST(rst), .POR(por), .CS_N(cs_n), .IOR_N(ior_n), .IOW_N(iow_n),
    .ADDR(adr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(), .STATUS_SELECT_IN_N(ss_n),
    .INTERRUPT_MODE_SELECT(1'b0), .CTS_N(cts_n), .DSR_N(1'b1), .RI_N(1'b1), .CD_N(1'b1),
    .RX_CHAR(rxc), .RX_CHAR_VALID(rxv), .RX_STORE_VALID(rsv), .RX_STORE_DATA(rsd),
    .RX_FIFO_LEVEL(lvl), .TX_GO(go), .FLOW_CHAR_VALID(fcv), .FLOW_CHAR(fc), .FLOW_CHAR_READY(fifo_control_reg),
    .LSR_STATUS(8'h60), .TX_SERIAL_IN(txs), .TX(), .INFRARED_TX_IN(txs), .INFRARED_TX_OUT(),
    .CH_RX_READY_N(rrdy), .CH_TX_READY_N(trdy), .RECEIVE_READY_OUT_N(), .TRANSMIT_READY_OUT_N(),
    .RTS_N(rts), .DTR_N(), .INT_OUT(), .INT_OE_N(), .IRQ_N_OUT(), .IRQ_OE_N(), .DIVISOR(dv),
    .FRAC_DIVISOR());
  uefc_peer i_uefc_peer (.clk(clk), .valid(fcv), .ch(fc), .ready(fifo_control_reg), .last(last), .num(num));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Chip select outlives the strobe so the synced edge sees it
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    adr = a;
    din = d;
    cs_n = 0;
    iow_n = 0;
    cyc(5);
    iow_n = 1;
    cyc(4);
    cs_n = 1;
    cyc(4);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    adr = a;
    cs_n = 0;
    ior_n = 0;
    cyc(6);
    chk(dout, e);
    ior_n = 1;
    cyc(4);
    cs_n = 1;
    cyc(4);
  endtask
  task automatic rx(input logic [7:0] c, input logic e);
    rxc = c;
    rxv = 1;
    cyc(1);
    rxv = 0;
    chk(rsv, e);
    cyc(1);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
  initial begin
    cyc(12);
    rst = 0;
    por = 0;
    cyc(2);
    chk(dv, 16'h0001);
    rc(OFS_7, 8'hFF);
    rc(OFS_2, 8'h01);
    wr(OFS_3, LCR_ENH_KEY);
    rc(OFS_2, 8'h00);
    for (int i = 4; i < 8; i++) begin
      rc(i[2:0], 8'h00);
      wr(i[2:0], 8'h50 + i[7:0]);
    end
    for (int i = 4; i < 8; i++) rc(i[2:0], 8'h50 + i[7:0]);
    $display("reset and character registers done");
    wr(OFS_3, 8'h00);
    wr(OFS_1, 8'hFF);
    rc(OFS_1, 8'h0F);
    wr(OFS_3, LCR_ENH_KEY);
    wr(OFS_2, 8'h10);
    wr(OFS_3, 8'h00);
    wr(OFS_1, 8'hA0);
    rc(OFS_1, 8'hA0);
    wr(OFS_3, LCR_ENH_KEY);
    wr(OFS_2, 8'h00);
    wr(OFS_3, 8'h00);
    wr(OFS_1, 8'h5F);
    rc(OFS_1, 8'hAF);
    trdy = 4'h3;
    rrdy = 4'h9;
    ss_n = 0;
    cyc(6);
    chk(dout, 8'h9C);
    ss_n = 1;
    wr(OFS_4, 8'h02);
    chk(rts, 1'b0);
    wr(OFS_4, 8'h00);
    chk(rts, 1'b1);
    $display("protection, status and modem pins done");
    wr(OFS_3, LCR_ENH_KEY);
    wr(OFS_2, 8'h80);
    cts_n = 1;
    cyc(6);
    chk(go, 1'b0);
    cts_n = 0;
    cyc(6);
    chk(go, 1'b1);
    wr(OFS_2, 8'h00);
    wr(OFS_2, 8'h08);
    lvl = 7'h08;
    cyc(20);
    chk(last, 8'h56);
    lvl = 7'h00;
    cyc(20);
    chk(last, 8'h54);
    wr(OFS_2, 8'h00);
    wr(OFS_2, 8'h0C);
    lvl = 7'h08;
    cyc(30);
    chk(last, 8'h57);
    chk(num[15:0], 16'h0004);
    lvl = 7'h00;
    cyc(30);
    chk(last, 8'h55);
    wr(OFS_2, 8'h00);
    wr(OFS_2, 8'h07);
    lvl = 7'h08;
    cyc(20);
    chk(last, 8'h57);
    lvl = 7'h00;
    cyc(20);
    chk(last, 8'h55);
    rx(8'h56, 1'b0);
    chk(go, 1'b0);
    rx(8'h55, 1'b0);
    chk(go, 1'b1);
    wr(OFS_2, 8'h00);
    wr(OFS_2, 8'h03);
    rx(8'h56, 1'b1);
    rx(8'h57, 1'b0);
    chk(go, 1'b0);
    wr(OFS_2, 8'h00);
    wr(OFS_2, 8'h20);
    rx(8'h57, 1'b1);
    chk(rsd, 8'h57);
    wr(OFS_3, 8'h00);
    rc(OFS_2, 8'h30);
    wr(OFS_3, LCR_ENH_KEY);
    wr(OFS_2, 8'h00);
    wr(OFS_2, 8'h21);
    rx(8'h57, 1'b0);
    chk(go, 1'b0);
    wr(OFS_2, 8'h00);
    wr(OFS_2, 8'h40);
    wr(OFS_3, 8'h00);
    wr(OFS_4, 8'h02);
    lvl = 7'h10;
    cyc(3);
    chk(rts, 1'b1);
    lvl = 7'h00;
    cyc(3);
    chk(rts, 1'b0);
    $display("flow control done");
    wr(OFS_3, 8'h80);
    wr(OFS_0, 8'h22);
    rst = 1;
    cyc(2);
    rst = 0;
    cyc(2);
    chk(dv, 16'h0022);
    $display("reset pin done");
    end_sim();
  end
endmodule
